// ==== design/daom_pkg.sv ====
// Function
// (RULE1) Each channel drives a 10-bit parallel sample word, bit 9 most significant.
// (RULE2) Output enable low pin high puts that channel's data outputs in tristate.
// (RULE3) Out-of-range asserts when the centred result clips, before the maximum code; code flags only results above 1ff or below e00, already at the end codes.
// (RULE4) While out of range, word forced all ones for over, all zeros for under; code gives 1ff and 200 instead in two's complement.
// (RULE5) Format select low gives offset binary, high gives two's complement.
// (RULE6) Offset binary: 3ff top, 000 bottom, 200 above and 1ff below mid-scale.
// (RULE7) Two's complement: 1ff top, 200 bottom, 000 above and 3ff below mid-scale.
// (RULE8) Power-down low enters power-down, overriding every other pin including sleep.
// (RULE9) Power-down turns off all circuitry and clock; its recovery is the slowest.
// (RULE10) Sleep selection powers channels down independently or sleeps the whole chip.
// (RULE11) Sleep stops internal clocking but keeps low-bandwidth circuitry on; faster restart.
// (RULE12) Controller keeps sampling clock running in idle; restarts it before going active.
// (RULE13) After power-up the controller holds power-down low for at least one clock.
// (RULE14) Controller keeps sampling clock running through reset power-down until active.
// (RULE15) Controller may instead hold power-down low during power-up, releasing when stable.
// (RULE16) Sleep code 00 all asleep, 01 channel 0 only, 10 channel 1 only, 11 both.
// (RULE17) Each channel's out-of-range flag is high while its input is out of range.
// (RULE18) All conversion timing uses only the rising sampling clock edge.
// (RULE19) Each active channel updates word and flag together per edge, fixed latency.
package daom_pkg;

    // ==========================================================
    // Widths
    localparam int WORD_W       = 10;
    localparam int RAW_W        = 12;
    localparam int PIPE_LATENCY = 3;
    localparam int ADDR_W       = 4;
    localparam int DATA_W       = 32;
    localparam int EV_W         = 4;
    localparam int WAKE_W       = 8;

    // ==========================================================
    // Register offsets, event positions and reset values
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_CLEAR  = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_ENABLE = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_MODE   = 4'hc;
    localparam int                EV_FLAG0    = 0;
    localparam int                EV_FLAG1    = 1;
    localparam int                EV_DOWN     = 2;
    localparam int                EV_ACTIVE   = 3;
    localparam logic [EV_W-1:0]   STATUS_RST  = 4'h0;
    localparam logic [EV_W-1:0]   ENABLE_RST  = 4'h0;

    // ==========================================================
    // Wake-up counts in sampling clock edges
    localparam logic [WAKE_W-1:0] PD_WAKE_EDGES    = 8'h40;
    localparam logic [WAKE_W-1:0] SLEEP_WAKE_EDGES = 8'h08;

    // ==========================================================
    // Codes
    localparam logic [WORD_W-1:0]       CODE_ALL_ONES  = 10'h3ff;
    localparam logic [WORD_W-1:0]       CODE_ALL_ZEROS = 10'h000;
    localparam logic [WORD_W-1:0]       CODE_MSB       = 10'h200;
    localparam logic signed [RAW_W-1:0] RAW_MAX        = 12'sh1ff;
    localparam logic signed [RAW_W-1:0] RAW_MIN        = 12'she00;
    localparam logic [1:0]              SLEEP_ALL      = 2'h0;

    // ==========================================================
    // Types
    typedef enum logic [2:0] {ST_UNINIT, ST_DOWN, ST_WAKE, ST_SLEEP, ST_ACTIVE} daom_state_e;

    typedef struct packed {
        logic       sample_clock;
        logic       powerdown_low;
        logic [1:0] sleep_select;
        logic       format_select;
        logic [1:0] oe_low;
    } daom_pins_s;

    typedef struct packed {
        logic [WORD_W-1:0] word;
        logic              flag;
    } daom_sample_s;

    localparam daom_pins_s PINS_RST = '{sample_clock: 1'b0, powerdown_low: 1'b1,
                                        sleep_select: 2'h0, format_select: 1'b0,
                                        oe_low: 2'h3};
    localparam daom_sample_s SAMPLE_RST = '0;

endpackage

// ==== design/daom_sync.sv ====
`timescale 1ns/1ps
module daom_sync import daom_pkg::*; #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] level
);

    logic [W-1:0] s1_reg, s2_reg, s3_reg, lvl_reg;
    logic [W-1:0] s1_next, s2_next, s3_next, lvl_next;
    logic [W-1:0] agree;

    // ==========================================================
    // Three stages; level follows once stages two and three agree
    always_comb begin
        s1_next  = async_in;
        s2_next  = s1_reg;
        s3_next  = s2_reg;
        agree    = ~(s2_reg ^ s3_reg);
        lvl_next = (agree & s3_reg) | (~agree & lvl_reg);
    end

    // Registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg  <= RST_VAL;
            s2_reg  <= RST_VAL;
            s3_reg  <= RST_VAL;
            lvl_reg <= RST_VAL;
        end else begin
            s1_reg  <= s1_next;
            s2_reg  <= s2_next;
            s3_reg  <= s3_next;
            lvl_reg <= lvl_next;
        end
    end

    assign level = lvl_reg;

endmodule

// ==== design/daom_chan.sv ====
`timescale 1ns/1ps
module daom_chan import daom_pkg::*; #(
    parameter int LATENCY = PIPE_LATENCY
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             sample_en,
    input  wire logic             active,
    input  wire logic             twos,
    input  wire logic [RAW_W-1:0] raw_code,
    output daom_sample_s          out
);

    daom_sample_s pipe_reg  [LATENCY];
    daom_sample_s pipe_next [LATENCY];

    // ==========================================================
    // Clamp, flag and format one centred result
    function automatic daom_sample_s convert(input logic [RAW_W-1:0] raw, input logic tc);
        logic         over;
        logic         under;
        daom_sample_s s;
        over  = $signed(raw) > RAW_MAX;                          // RULE3
        under = $signed(raw) < RAW_MIN;                          // RULE3
        s.flag = over | under;                                   // RULE17
        if (over) begin
            s.word = CODE_ALL_ONES;                              // RULE4
        end else if (under) begin
            s.word = CODE_ALL_ZEROS;                             // RULE4
        end else begin
            s.word = raw[WORD_W-1:0] ^ CODE_MSB;                 // RULE6
        end
        if (tc) begin
            s.word = s.word ^ CODE_MSB;                          // RULE5 RULE7
        end
        return s;
    endfunction

    // Pipeline advances only on a sample edge; a sleeping channel is flushed
    always_comb begin
        pipe_next = pipe_reg;
        if (!active) begin
            for (int i = 0; i < LATENCY; i++) begin
                pipe_next[i] = SAMPLE_RST;                       // RULE10
            end
        end else if (sample_en) begin
            pipe_next[0] = convert(raw_code, twos);              // RULE18
            for (int i = 1; i < LATENCY; i++) begin
                pipe_next[i] = pipe_reg[i-1];                    // RULE19
            end
        end
    end

    // Registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < LATENCY; i++) begin
                pipe_reg[i] <= SAMPLE_RST;
            end
        end else begin
            pipe_reg <= pipe_next;
        end
    end

    assign out = pipe_reg[LATENCY-1];                            // RULE1

    // ==========================================================
    // Checks
    sequence s_take;
        sample_en && active;
    endsequence

    property p_over_clamp;
        @(posedge clk) disable iff (!rst_n)
        (s_take ##0 ($signed(raw_code) > RAW_MAX)) |=>
            pipe_reg[0].flag && pipe_reg[0].word == ($past(twos) ? ~CODE_MSB : CODE_ALL_ONES);
    endproperty
    a_over_clamp: assert property (p_over_clamp) else $error("overrange not clamped"); // RULE4

    property p_under_clamp;
        @(posedge clk) disable iff (!rst_n)
        (s_take ##0 ($signed(raw_code) < RAW_MIN)) |=>
            pipe_reg[0].flag && pipe_reg[0].word == ($past(twos) ? CODE_MSB : CODE_ALL_ZEROS);
    endproperty
    a_under_clamp: assert property (p_under_clamp) else $error("underrange not clamped"); // RULE17

    property p_mid_code;
        @(posedge clk) disable iff (!rst_n)
        (s_take ##0 (raw_code == 12'h000)) |=>
            !pipe_reg[0].flag && pipe_reg[0].word == ($past(twos) ? CODE_ALL_ZEROS : CODE_MSB);
    endproperty
    a_mid_code: assert property (p_mid_code) else $error("mid-scale code wrong"); // RULE7

    property p_hold;
        @(posedge clk) disable iff (!rst_n)
        active && !sample_en |=> $stable(out);
    endproperty
    a_hold: assert property (p_hold) else $error("output moved without sample edge"); // RULE19

    property p_sleep_clear;
        @(posedge clk) disable iff (!rst_n)
        !active |=> out == SAMPLE_RST;
    endproperty
    a_sleep_clear: assert property (p_sleep_clear) else $error("sleeping channel not idle"); // RULE10

endmodule

// ==== design/daom_top.sv ====
`timescale 1ns/1ps
module daom_top import daom_pkg::*; #(
    parameter int LATENCY = PIPE_LATENCY
) (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic                       sample_clock,
    input  wire logic                       powerdown_low,
    input  wire logic [1:0]                 sleep_select,
    input  wire logic                       format_select,
    input  wire logic [1:0]                 output_enable_low,
    input  wire logic [1:0][RAW_W-1:0]      raw_code,
    input  wire logic [ADDR_W-1:0]          reg_addr,
    input  wire logic [DATA_W-1:0]          reg_wdata,
    input  wire logic                       reg_write,
    input  wire logic                       reg_read,
    output logic      [DATA_W-1:0]          reg_rdata,
    output logic      [1:0][WORD_W-1:0]     sample_word,
    output logic      [1:0]                 sample_word_oe,
    output logic      [1:0]                 out_of_range_flag,
    output logic                            output_clock,
    output logic                            core_clock_enable,
    output logic                            bias_enable,
    output logic      [1:0]                 chan_power,
    output logic                            irq
);

    // ==========================================================
    // Pin synchronisers
    daom_pins_s pins_raw;
    daom_pins_s pins_s;
    logic       pd_low_s;
    logic [1:0] sleep_s;

    assign pins_raw = '{sample_clock: sample_clock, powerdown_low: powerdown_low,
                        sleep_select: sleep_select, format_select: format_select,
                        oe_low: output_enable_low};

    daom_sync #(
        .W       ($bits(daom_pins_s)),
        .RST_VAL (PINS_RST)
    ) u_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in (pins_raw),
        .level    (pins_s)
    );

    assign pd_low_s = pins_s.powerdown_low;
    assign sleep_s  = pins_s.sleep_select;

    // ==========================================================
    // Sampling clock rising edge detection
    logic sclk_prev_reg;
    logic sclk_prev_next;
    logic sample_en;

    // Only the rising edge makes a strobe
    always_comb begin
        sclk_prev_next = pins_s.sample_clock;
        sample_en      = pins_s.sample_clock & ~sclk_prev_reg;   // RULE18
    end

    // Edge register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_prev_reg <= 1'b0;
        end else begin
            sclk_prev_reg <= sclk_prev_next;
        end
    end

    // ==========================================================
    // Operating mode state machine
    daom_state_e       state_reg, state_next;
    logic [WAKE_W-1:0] wake_cnt_reg, wake_cnt_next;

    // Power-down overrides everything; wake-up counts sampling edges
    always_comb begin
        state_next    = state_reg;
        wake_cnt_next = wake_cnt_reg;
        if (!pd_low_s) begin
            state_next = ST_DOWN;                                // RULE8
        end else begin
            unique case (state_reg)
                ST_UNINIT: begin
                    state_next = ST_UNINIT;                      // RULE13
                end
                ST_DOWN: begin
                    state_next    = ST_WAKE;
                    wake_cnt_next = PD_WAKE_EDGES;               // RULE9
                end
                ST_WAKE: begin
                    if (sample_en) begin                         // RULE12
                        if (wake_cnt_reg == 8'h01) begin
                            state_next = (sleep_s == SLEEP_ALL) ? ST_SLEEP : ST_ACTIVE;
                        end else begin
                            wake_cnt_next = wake_cnt_reg - 8'h01;
                        end
                    end
                end
                ST_SLEEP: begin
                    if (sleep_s != SLEEP_ALL) begin
                        state_next    = ST_WAKE;
                        wake_cnt_next = SLEEP_WAKE_EDGES;        // RULE11
                    end
                end
                ST_ACTIVE: begin
                    if (sleep_s == SLEEP_ALL) begin
                        state_next = ST_SLEEP;                   // RULE16
                    end
                end
            endcase
        end
    end

    // State registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg    <= ST_UNINIT;
            wake_cnt_reg <= 8'h00;
        end else begin
            state_reg    <= state_next;
            wake_cnt_reg <= wake_cnt_next;
        end
    end

    // ==========================================================
    // Power, clock and output driver controls
    logic       core_clk_reg, core_clk_next;
    logic       bias_reg, bias_next;
    logic [1:0] chan_power_reg, chan_power_next;
    logic [1:0] oe_reg, oe_next;
    logic       oclk_reg, oclk_next;

    // Controls follow the next state so they line up with it
    always_comb begin
        core_clk_next   = (state_next == ST_WAKE) || (state_next == ST_ACTIVE);  // RULE9 RULE11
        bias_next       = (state_next == ST_WAKE) || (state_next == ST_SLEEP) ||
                          (state_next == ST_ACTIVE);                             // RULE11
        chan_power_next = (state_next == ST_ACTIVE) ? sleep_s : 2'h0;           // RULE10 RULE16
        oe_next         = ~pins_s.oe_low;                                        // RULE2
        oclk_next       = core_clk_next & ~pins_s.sample_clock;  // Data change on its fall
    end

    // Control registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            core_clk_reg   <= 1'b0;
            bias_reg       <= 1'b0;
            chan_power_reg <= 2'h0;
            oe_reg         <= 2'h0;
            oclk_reg       <= 1'b0;
        end else begin
            core_clk_reg   <= core_clk_next;
            bias_reg       <= bias_next;
            chan_power_reg <= chan_power_next;
            oe_reg         <= oe_next;
            oclk_reg       <= oclk_next;
        end
    end

    // ==========================================================
    // Channel datapaths
    daom_sample_s chan_out [2];

    for (genvar g = 0; g < 2; g++) begin : g_chan
        daom_chan #(
            .LATENCY (LATENCY)
        ) u_chan (
            .clk       (clk),
            .rst_n     (rst_n),
            .sample_en (sample_en),
            .active    (chan_power_reg[g]),
            .twos      (pins_s.format_select),
            .raw_code  (raw_code[g]),
            .out       (chan_out[g])
        );
        assign sample_word[g]       = chan_out[g].word;         // RULE1
        assign out_of_range_flag[g] = chan_out[g].flag;         // RULE17
    end

    assign sample_word_oe    = oe_reg;
    assign output_clock      = oclk_reg;
    assign core_clock_enable = core_clk_reg;
    assign bias_enable       = bias_reg;
    assign chan_power        = chan_power_reg;

    // ==========================================================
    // Events, status, enable and register port
    logic [1:0]        flag_prev_reg, flag_prev_next;
    logic [EV_W-1:0]   ev;
    logic [EV_W-1:0]   clear_bits;
    logic [EV_W-1:0]   status_reg, status_next;
    logic [EV_W-1:0]   enable_reg, enable_next;
    logic              irq_reg, irq_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;

    // Sticky status, set wins over clear; read data valid one cycle
    always_comb begin
        flag_prev_next      = {chan_out[1].flag, chan_out[0].flag};
        ev                  = '0;
        ev[EV_FLAG0]        = chan_out[0].flag & ~flag_prev_reg[0];
        ev[EV_FLAG1]        = chan_out[1].flag & ~flag_prev_reg[1];
        ev[EV_DOWN]         = (state_next == ST_DOWN) && (state_reg != ST_DOWN);
        ev[EV_ACTIVE]       = (state_next == ST_ACTIVE) && (state_reg != ST_ACTIVE);
        clear_bits          = (reg_write && reg_addr == ADDR_CLEAR) ? reg_wdata[EV_W-1:0] : '0;
        status_next         = (status_reg & ~clear_bits) | ev;
        enable_next         = (reg_write && reg_addr == ADDR_ENABLE) ? reg_wdata[EV_W-1:0]
                                                                     : enable_reg;
        irq_next            = |(status_next & enable_next);
        rdata_next          = '0;
        if (reg_read) begin
            unique case (reg_addr)
                ADDR_STATUS: rdata_next = DATA_W'(status_reg);
                ADDR_ENABLE: rdata_next = DATA_W'(enable_reg);
                ADDR_MODE:   rdata_next = DATA_W'({pins_s.format_select, chan_power_reg,
                                                   state_reg});
                default:     rdata_next = '0;
            endcase
        end
    end

    // Register file
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_prev_reg <= 2'h0;
            status_reg    <= STATUS_RST;
            enable_reg    <= ENABLE_RST;
            irq_reg       <= 1'b0;
            rdata_reg     <= '0;
        end else begin
            flag_prev_reg <= flag_prev_next;
            status_reg    <= status_next;
            enable_reg    <= enable_next;
            irq_reg       <= irq_next;
            rdata_reg     <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign irq       = irq_reg;

    // ==========================================================
    // Checks
    property p_pd_wins;
        @(posedge clk) disable iff (!rst_n)
        !pd_low_s |=> state_reg == ST_DOWN && chan_power_reg == 2'h0;
    endproperty
    a_pd_wins: assert property (p_pd_wins) else $error("power-down did not win"); // RULE8

    property p_down_off;
        @(posedge clk) disable iff (!rst_n)
        state_reg == ST_DOWN |-> !core_clk_reg && !bias_reg && !oclk_reg;
    endproperty
    a_down_off: assert property (p_down_off) else $error("circuitry on in power-down"); // RULE9

    property p_sleep_bias;
        @(posedge clk) disable iff (!rst_n)
        state_reg == ST_SLEEP |-> bias_reg && !core_clk_reg && chan_power_reg == 2'h0;
    endproperty
    a_sleep_bias: assert property (p_sleep_bias) else $error("sleep controls wrong"); // RULE11

    sequence s_down_to_wake;
        state_reg == ST_DOWN ##1 state_reg == ST_WAKE;
    endsequence

    sequence s_sleep_to_wake;
        state_reg == ST_SLEEP ##1 state_reg == ST_WAKE;
    endsequence

    property p_pd_wake_long;
        @(posedge clk) disable iff (!rst_n)
        s_down_to_wake |-> wake_cnt_reg == PD_WAKE_EDGES;
    endproperty
    a_pd_wake_long: assert property (p_pd_wake_long) else $error("power-down wake count"); // RULE9

    property p_sleep_wake_short;
        @(posedge clk) disable iff (!rst_n)
        s_sleep_to_wake |-> wake_cnt_reg == SLEEP_WAKE_EDGES;
    endproperty
    a_sleep_wake_short: assert property (p_sleep_wake_short) else $error("sleep wake count"); // RULE11

    property p_chan_select;
        @(posedge clk) disable iff (!rst_n)
        state_reg == ST_ACTIVE |-> chan_power_reg == $past(sleep_s);
    endproperty
    a_chan_select: assert property (p_chan_select) else $error("channel power mismatch"); // RULE16

    property p_tristate;
        @(posedge clk) disable iff (!rst_n)
        pins_s.oe_low[0] && pins_s.oe_low[1] |=> sample_word_oe == 2'h0;
    endproperty
    a_tristate: assert property (p_tristate) else $error("outputs driven while disabled"); // RULE2

    property p_set_wins;
        @(posedge clk) disable iff (!rst_n)
        ev[EV_FLAG0] |=> status_reg[EV_FLAG0] && (irq_reg || !enable_reg[EV_FLAG0]);
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("flag event lost"); // RULE17

    property p_uninit;
        @(posedge clk) disable iff (!rst_n)
        state_reg == ST_UNINIT && pd_low_s |=> state_reg == ST_UNINIT && !core_clk_reg;
    endproperty
    a_uninit: assert property (p_uninit) else $error("left reset without power-down"); // RULE13

endmodule

// ==== sim/daom_capture_model.sv ====
`timescale 1ns/1ps
module daom_capture_model import daom_pkg::*; (
    input  wire logic [1:0][RAW_W-1:0] raw_next,
    output logic                       sample_clock,
    output logic [1:0][RAW_W-1:0]      raw_code
);
    // ==========================================================
    // Sampling clock, 48 ns, off phase, never stopped in idle modes
    initial begin
        sample_clock = 1'b0;
        #1.7;
        forever begin
            #24;
            sample_clock = ~sample_clock;
        end
    end
    // Result launched at the rising edge, held for the whole period
    initial raw_code = '0;
    always @(posedge sample_clock) raw_code <= raw_next;
endmodule

// ==== sim/daom_top_tb_top.sv ====
`timescale 1ns/1ps
module daom_top_tb_top import daom_pkg::*;;
    logic                    clk, rst_n, powerdown_low, format_select, reg_write, reg_read;
    logic [1:0]              sleep_select, output_enable_low, sample_word_oe, out_of_range_flag;
    logic [1:0]              chan_power;
    logic                    sample_clock, output_clock, core_clock_enable, bias_enable, irq;
    logic [1:0][RAW_W-1:0]   raw_next, raw_code;
    logic [ADDR_W-1:0]       reg_addr;
    logic [DATA_W-1:0]       reg_wdata, reg_rdata;
    logic [1:0][WORD_W-1:0]  sample_word;
    logic [RAW_W-1:0]        raw_t [6] = '{12'h258, 12'h1ff, 12'h000, 12'hfff, 12'he00, 12'hda8};
    logic [WORD_W-1:0]       off_t [6] = '{10'h3ff, 10'h3ff, 10'h200, 10'h1ff, 10'h000, 10'h000};
    logic [WORD_W-1:0]       two_t [6] = '{10'h1ff, 10'h1ff, 10'h000, 10'h3ff, 10'h200, 10'h200};
    logic                    flg_t [6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    logic [1:0]              slp_t [4] = '{2'h1, 2'h2, 2'h0, 2'h3};
    int                      n_mismatch, compares;

    daom_capture_model daom_capture_model_i (.raw_next(raw_next), .sample_clock(sample_clock),
        .raw_code(raw_code));
    daom_top daom_top_i (.clk(clk), .rst_n(rst_n), .sample_clock(sample_clock),
        .powerdown_low(powerdown_low), .sleep_select(sleep_select),
        .format_select(format_select), .output_enable_low(output_enable_low),
        .raw_code(raw_code), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .sample_word(sample_word), .sample_word_oe(sample_word_oe),
        .out_of_range_flag(out_of_range_flag), .output_clock(output_clock),
        .core_clock_enable(core_clock_enable), .bias_enable(bias_enable),
        .chan_power(chan_power), .irq(irq));

    // ==========================================================
    // Helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // One-cycle write or read strobe; read data checked by caller
    task automatic reg_op(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_write <= wr;
        reg_read <= ~wr;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
        reg_read <= 1'b0;
        #1;
    endtask
    task automatic tally_and_finish;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_power_up;
        cyc(10);
        @(posedge clk) powerdown_low <= 1'b1;
        cyc(820);
        chk({core_clock_enable, bias_enable, chan_power}, 4'hf);
        chk(irq, 1'b0);
    endtask
    task automatic t_format;
        for (int f = 0; f < 2; f++) begin
            for (int i = 0; i < 6; i++) begin
                @(posedge clk);
                format_select <= f[0];
                raw_next <= {raw_t[5-i], raw_t[i]};
                cyc(100);
                chk(sample_word, f ? {two_t[5-i], two_t[i]}
                                   : {off_t[5-i], off_t[i]});
                chk(out_of_range_flag, {flg_t[5-i], flg_t[i]});
            end
        end
    endtask
    task automatic t_oe;
        @(posedge clk) output_enable_low <= 2'b01;
        cyc(8);
        chk(sample_word_oe, 2'b10);
        @(posedge clk) output_enable_low <= 2'b11;
        cyc(8);
        chk(sample_word_oe, 2'b00);
        @(posedge clk) output_enable_low <= 2'b00;
        cyc(8);
        chk(sample_word_oe, 2'b11);
    endtask
    task automatic t_sleep;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk) sleep_select <= slp_t[i];
            cyc(150);
            chk({core_clock_enable, bias_enable, chan_power},
                {slp_t[i] != 2'h0, 1'b1, slp_t[i]});
            if (slp_t[i] == 2'h1) chk(sample_word[1], 10'h000);
        end
    endtask
    task automatic t_pd_irq;
        reg_op(1'b1, ADDR_ENABLE, 32'h4);
        reg_op(1'b0, ADDR_ENABLE, 32'h0);
        chk(reg_rdata, 32'h4);
        @(posedge clk) powerdown_low <= 1'b0;
        cyc(10);
        chk({core_clock_enable, bias_enable, chan_power, irq, output_clock}, 6'h02);
        reg_op(1'b0, ADDR_STATUS, 32'h0);
        chk(reg_rdata[2], 1'b1);
        reg_op(1'b0, ADDR_MODE, 32'h0);
        chk(reg_rdata, 32'h21);
        reg_op(1'b1, ADDR_CLEAR, 32'h4);
        cyc(2);
        chk(irq, 1'b0);
        reg_op(1'b0, 4'h2, 32'h0);
        chk(reg_rdata, 32'h0);
    endtask

    // ==========================================================
    // Clock, reset, sequence and watchdog
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        {rst_n, powerdown_low, format_select, reg_write, reg_read} = '0;
        {sleep_select, output_enable_low, raw_next, reg_addr, reg_wdata} = '0;
        sleep_select = 2'h3;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_power_up();
        t_format();
        t_oe();
        t_sleep();
        t_pd_irq();
        tally_and_finish();
    end
    initial begin
        #50000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule
